// >>> hdl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // Source count and order limits
  localparam int SRC_COUNT = 21;
  localparam int ORDER_W = 5;
  localparam logic [4:0] RESERVED_ORDER = 5'h11;
  localparam logic [20:0] RESERVED_MASK = 21'h020000;
  // Primary flags that hardware clears when vectoring
  localparam logic [20:0] HW_CLEAR_MASK = 21'h000005;

  // Vector map
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] FIRST_VECTOR = 16'h0003;
  localparam logic [15:0] LAST_VECTOR = 16'h00A3;
  localparam int VECTOR_STEP_SHIFT = 3;

  // Register byte offsets on APB
  localparam logic [7:0] OFS_FIRST_EN = 8'h00;
  localparam logic [7:0] OFS_SECOND_EN = 8'h04;
  localparam logic [7:0] OFS_THIRD_EN = 8'h08;
  localparam logic [7:0] OFS_FIRST_PRIO = 8'h0C;
  localparam logic [7:0] OFS_SECOND_PRIO = 8'h10;
  localparam logic [7:0] OFS_THIRD_PRIO = 8'h14;
  localparam logic [7:0] OFS_PEND_A = 8'h18;
  localparam logic [7:0] OFS_PEND_B = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions and reset values
  localparam int GLOBAL_EN_BIT = 7;
  localparam int FIRST_SRC_BITS = 7;
  localparam int SECOND_SRC_BITS = 8;
  localparam int THIRD_SRC_BITS = 6;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] FIRST_PRIO_READ_ONE = 8'h80;
  localparam logic [20:0] PEND_RESET = 21'h000000;

  // Latency figures in system clocks
  localparam int DETECT_CLOCKS = 1;
  localparam int CALL_CLOCKS = 5;
  localparam int MIN_RESPONSE_CLOCKS = DETECT_CLOCKS + CALL_CLOCKS;

  // Sequencer handshake into the controller
  typedef struct packed {
    logic insn_last;  // Final clock of the current instruction
    logic insn_is_return_from_interrupt;  // That instruction is a return_from_interrupt
    logic stall;  // Core stalled (flash write, USB buffer access)
  } cpu_seq_type;

  // Vectoring request toward the sequencer
  typedef struct packed {
    logic req;  // Start long_subroutine_call now
    logic high;  // Serviced level is high
    logic [15:0] vector;  // Call target
  } cpu_req_type;

  // Registered arbitration result
  typedef struct packed {
    logic valid;
    logic high;
    logic [4:0] order;
  } detect_type;

endpackage

// >>> hdl/two_level_interrupt_controller.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module two_level_interrupt_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [20:0] flag_set_a,
  input wire logic [20:0] flag_set_b,
  input wire irq_ctrl_pkg::cpu_seq_type cpu_seq,
  output irq_ctrl_pkg::cpu_req_type cpu_req
);
  import irq_ctrl_pkg::*;

  // Lowest set bit wins the fixed order
  function automatic logic [4:0] lowest_order(input logic [20:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = SRC_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Order to call target, 8-byte spacing
  function automatic logic [15:0] order_vector(input logic [4:0] ord);
    return FIRST_VECTOR + (16'(ord) << VECTOR_STEP_SHIFT);
  endfunction

  // Software-visible registers
  logic [7:0] first_enable_reg_ff;  // Bit 7 is global_irq_enable
  logic [7:0] second_enable_reg_ff;
  logic [7:0] third_enable_reg_ff;
  logic [7:0] first_priority_reg_ff;
  logic [7:0] second_priority_reg_ff;
  logic [7:0] third_priority_reg_ff;
  logic [20:0] pend_a_ff;  // Primary pending flags
  logic [20:0] pend_b_ff;  // Secondary pending flags
  // Nesting state
  logic in_low_ff;  // Low level routine active
  logic in_high_ff;  // High level routine active
  detect_type detect_ff;  // Winner sampled one clock ago
  // Bus answer registers
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  cpu_req_type cpu_req_ff;

  // Bus phases
  logic setup_phase;
  logic bus_write;
  logic global_irq_enable;
  logic [20:0] src_enable;
  logic [20:0] src_prio;
  logic [20:0] src_flag;
  logic [20:0] src_req;
  logic [20:0] src_req_high;
  logic vector_now;  // Vectoring at this edge
  logic return_from_interrupt_now;  // Return completes at this edge
  logic eligible;
  logic [20:0] hw_clear;
  logic [20:0] nxt_pend_a;
  logic [20:0] nxt_pend_b;
  logic addr_known;
  logic [31:0] read_mux;

  assign setup_phase = psel & ~penable;
  // Write lands on the access edge the master samples pready
  assign bus_write = psel & penable & pready_ff & pwrite;

  // Flatten enables and priorities by fixed order
  assign global_irq_enable = first_enable_reg_ff[GLOBAL_EN_BIT];
  assign src_enable = {third_enable_reg_ff[THIRD_SRC_BITS-1:0],
                       second_enable_reg_ff,
                       first_enable_reg_ff[FIRST_SRC_BITS-1:0]};
  assign src_prio = {third_priority_reg_ff[THIRD_SRC_BITS-1:0],
                     second_priority_reg_ff,
                     first_priority_reg_ff[FIRST_SRC_BITS-1:0]};

  // Either flag of a source makes one shared request
  assign src_flag = pend_a_ff | pend_b_ff;
  // Disabled or reserved sources stay silent
  assign src_req = src_flag & src_enable & ~RESERVED_MASK
                   & {SRC_COUNT{global_irq_enable}};
  assign src_req_high = src_req & src_prio;

  // Detected winner may preempt only a lower level
  always_comb begin
    if (!detect_ff.valid || in_high_ff) begin
      eligible = 1'b0;
    end else if (detect_ff.high) begin
      eligible = 1'b1;
    end else begin
      eligible = ~in_low_ff;
    end
  end

  // Boundary, no stall; a call only when that instruction is not the return
  assign return_from_interrupt_now = cpu_seq.insn_last & cpu_seq.insn_is_return_from_interrupt & ~cpu_seq.stall;
  assign vector_now = eligible & cpu_seq.insn_last & ~cpu_seq.insn_is_return_from_interrupt
                      & ~cpu_seq.stall;

  // Only the winner's primary flag is cleared, and only if listed
  always_comb begin
    hw_clear = '0;
    if (vector_now) begin
      hw_clear[detect_ff.order] = HW_CLEAR_MASK[detect_ff.order];
    end
  end

  // Hardware clear, then software write, then hardware set wins
  always_comb begin
    nxt_pend_a = pend_a_ff & ~hw_clear;
    nxt_pend_b = pend_b_ff;
    if (bus_write && paddr == OFS_PEND_A) begin
      nxt_pend_a = pwdata[20:0];
    end
    if (bus_write && paddr == OFS_PEND_B) begin
      nxt_pend_b = pwdata[20:0];
    end
    nxt_pend_a = (nxt_pend_a | flag_set_a) & ~RESERVED_MASK;
    nxt_pend_b = (nxt_pend_b | flag_set_b) & ~RESERVED_MASK;
  end

  // Pending flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_a_ff <= PEND_RESET;
      pend_b_ff <= PEND_RESET;
    end else begin
      pend_a_ff <= nxt_pend_a;
      pend_b_ff <= nxt_pend_b;
    end
  end

  // Enable and priority registers; all sources start low level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_enable_reg_ff <= EN_RESET;
      second_enable_reg_ff <= EN_RESET;
      third_enable_reg_ff <= EN_RESET;
      first_priority_reg_ff <= PRIO_RESET;
      second_priority_reg_ff <= PRIO_RESET;
      third_priority_reg_ff <= PRIO_RESET;
    end else if (bus_write) begin
      case (paddr)
        OFS_FIRST_EN: begin
          first_enable_reg_ff <= pwdata[7:0];
        end
        OFS_SECOND_EN: begin
          second_enable_reg_ff <= pwdata[7:0];
        end
        OFS_THIRD_EN: begin
          third_enable_reg_ff <= pwdata[7:0] & 8'h3B;  // Bit 2 reserved
        end
        OFS_FIRST_PRIO: begin
          first_priority_reg_ff <= pwdata[7:0] & 8'h7F;
        end
        OFS_SECOND_PRIO: begin
          second_priority_reg_ff <= pwdata[7:0];
        end
        OFS_THIRD_PRIO: begin
          third_priority_reg_ff <= pwdata[7:0] & 8'h3B;
        end
        default: begin
          // Other offsets hold no enable state
        end
      endcase
    end
  end

  // Sample and decode every clock; high level first, then order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_ff <= '0;
    end else begin
      detect_ff.valid <= |src_req;
      detect_ff.high <= |src_req_high;
      detect_ff.order <= (|src_req_high) ? lowest_order(src_req_high)
                                         : lowest_order(src_req);
    end
  end

  // Nesting tracker; a return pops the innermost level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_low_ff <= 1'b0;
      in_high_ff <= 1'b0;
    end else if (vector_now) begin
      if (detect_ff.high) begin
        in_high_ff <= 1'b1;
      end else begin
        in_low_ff <= 1'b1;
      end
    end else if (return_from_interrupt_now) begin
      if (in_high_ff) begin
        in_high_ff <= 1'b0;
      end else begin
        in_low_ff <= 1'b0;
      end
    end
  end

  // One-clock call request; vector held until the next call
  // Using the winner from one clock back lets a just-disabled source
  // fire once when the next clock ends an instruction, of any length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_req_ff.req <= 1'b0;
      cpu_req_ff.high <= 1'b0;
      cpu_req_ff.vector <= RESET_VECTOR;
    end else begin
      cpu_req_ff.req <= vector_now;
      if (vector_now) begin
        cpu_req_ff.high <= detect_ff.high;
        cpu_req_ff.vector <= order_vector(detect_ff.order);
      end
    end
  end

  // Read decode, shared by data and error answers
  always_comb begin
    addr_known = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      OFS_FIRST_EN: begin
        read_mux[7:0] = first_enable_reg_ff;
      end
      OFS_SECOND_EN: begin
        read_mux[7:0] = second_enable_reg_ff;
      end
      OFS_THIRD_EN: begin
        read_mux[7:0] = third_enable_reg_ff;
      end
      OFS_FIRST_PRIO: begin
        read_mux[7:0] = first_priority_reg_ff | FIRST_PRIO_READ_ONE;
      end
      OFS_SECOND_PRIO: begin
        read_mux[7:0] = second_priority_reg_ff;
      end
      OFS_THIRD_PRIO: begin
        read_mux[7:0] = third_priority_reg_ff;
      end
      OFS_PEND_A: begin
        read_mux[20:0] = pend_a_ff;
      end
      OFS_PEND_B: begin
        read_mux[20:0] = pend_b_ff;
      end
      OFS_STATUS: begin
        read_mux[0] = in_low_ff;
        read_mux[1] = in_high_ff;
        read_mux[2] = detect_ff.valid;
        read_mux[3] = detect_ff.high;
        read_mux[8:4] = detect_ff.order;
        read_mux[31:16] = cpu_req_ff.vector;
      end
      default: begin
        addr_known = 1'b0;  // Unmapped: error, reads zero
      end
    endcase
  end

  // APB answer: ready in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
      pslverr_ff <= setup_phase & ~addr_known;
      if (setup_phase && !pwrite) begin
        prdata_ff <= read_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_req = cpu_req_ff;

  // Flag raised by a set pulse is visible next clock
  chk_flag_set_seen: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(flag_set_a & ~RESERVED_MASK))
      |=> ((pend_a_ff & $past(flag_set_a & ~RESERVED_MASK))
           == $past(flag_set_a & ~RESERVED_MASK)))
    else $error("pending flag not set by source");

  // Global enable low two clocks blocks any call
  chk_global_gate_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!global_irq_enable ##1 !global_irq_enable) |=> !cpu_req_ff.req)
    else $error("call issued while global enable low");

  // No call directly at a return boundary
  chk_return_from_interrupt_one_insn: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cpu_seq.insn_last && cpu_seq.insn_is_return_from_interrupt) |=> !cpu_req_ff.req)
    else $error("call issued at return boundary");

  // Stalled core never gets a call
  chk_stall_no_call: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_seq.stall |=> !cpu_req_ff.req)
    else $error("call issued during stall");

  // High routine is never preempted
  chk_high_no_preempt: assert property (
    @(posedge pclk) disable iff (!presetn)
    in_high_ff |=> !cpu_req_ff.req)
    else $error("high level routine preempted");

  // Call lands in the vector table, never reserved slot
  chk_vector_table: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_req_ff.req |-> (cpu_req_ff.vector[2:0] == 3'h3
      && cpu_req_ff.vector <= LAST_VECTOR
      && cpu_req_ff.vector != order_vector(RESERVED_ORDER)))
    else $error("vector outside table");

  // Call only after an instruction's final clock
  chk_req_boundary: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_req_ff.req |-> $past(cpu_seq.insn_last))
    else $error("call off instruction boundary");

  // Level pushed with each call
  chk_level_push: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_req_ff.req |-> (cpu_req_ff.high ? in_high_ff : in_low_ff))
    else $error("serviced level not recorded");

  // Fastest path: request one clock after detection
  chk_detect_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!in_low_ff && !in_high_ff && |src_req && !cpu_seq.stall
     ##1 (cpu_seq.insn_last && !cpu_seq.insn_is_return_from_interrupt && !cpu_seq.stall
          && !in_low_ff && !in_high_ff))
      |=> cpu_req_ff.req)
    else $error("detected request not serviced at boundary");

endmodule
`default_nettype wire

// >>> sim/cpu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
// Core sequencer stand-in: fixed-length instructions, call, stall
module cpu_seq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] insn_len,
  input wire logic stall_in,
  input wire logic return_from_interrupt_next,
  input wire irq_ctrl_pkg::cpu_req_type cpu_req,
  output irq_ctrl_pkg::cpu_seq_type cpu_seq
);
  import irq_ctrl_pkg::*;
  logic [3:0] left_ff; // Clocks left in this instruction
  // Instruction clock count; a stall freezes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 4'h0;
    end else if (cpu_req.req) begin
      left_ff <= 4'(CALL_CLOCKS - 1); // Call holds the core
    end else if (!stall_in) begin // Stalled core runs nothing
      left_ff <= (left_ff == 4'h0) ? insn_len - 4'h1 : left_ff - 4'h1;
    end
  end
  // No boundary inside a call or a stall
  always_comb begin
    cpu_seq.insn_last = left_ff == 4'h0 && !stall_in && !cpu_req.req;
    cpu_seq.insn_is_return_from_interrupt = return_from_interrupt_next; // Only read with insn_last
    cpu_seq.stall = stall_in;
  end
endmodule
`default_nettype wire

// >>> sim/test_two_level_interrupt_controller.sv
`timescale 1ns/1ns
`default_nettype none
module test_two_level_interrupt_controller;
  import irq_ctrl_pkg::*;
  // One source: order, second flag used, high level
  typedef struct {
    int ord;
    bit use_b;
    bit hi;
  } row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, got;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [20:0] flag_set_a, flag_set_b;
  logic [3:0] insn_len;
  logic stall_in, return_from_interrupt_next;
  cpu_seq_type cpu_seq;
  cpu_req_type cpu_req;
  int miscompares = 0;
  int n_compared = 0;
  int n_req = 0;
  int seen = 0;
  int cyc;
  row_type rows [7] = '{'{0, 0, 0}, '{2, 0, 1}, '{4, 1, 0},
    '{7, 0, 1}, '{14, 1, 0}, '{15, 0, 1}, '{20, 1, 1}};

  two_level_interrupt_controller DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_set_a(flag_set_a),
    .flag_set_b(flag_set_b), .cpu_seq(cpu_seq), .cpu_req(cpu_req));
  cpu_seq_model core (.pclk(pclk), .presetn(presetn),
    .insn_len(insn_len), .stall_in(stall_in), .return_from_interrupt_next(return_from_interrupt_next),
    .cpu_req(cpu_req), .cpu_seq(cpu_seq));

  // Clock, 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Count call pulses; the count lands one edge late
  always @(posedge pclk) begin
    if (cpu_req.req === 1'b1) begin
      n_req <= n_req + 1;
    end
  end

  // Verdict
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e,
      input string what);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e, input string what);
    cmp32({31'h0, g}, {31'h0, e}, what);
  endtask
  // APB transfer, then one idle clock so strobes never double up
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp1(n < 20, 1'b1, "pready");
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [20:0] a, input logic [20:0] b);
    flag_set_a <= a;
    flag_set_b <= b;
    @(posedge pclk);
    flag_set_a <= 21'h0;
    flag_set_b <= 21'h0;
  endtask
  // Wait for a call pulse, bounded; cyc gives the edges waited
  task automatic wait_req(input int lim);
    cyc = 0;
    while (n_req == seen && cyc < lim) begin
      @(posedge pclk);
      cyc++;
    end
    got = n_req != seen;
    seen = n_req;
  endtask
  // Enables are rewritten only once flags are cleared, so a disable
  // is never followed by a call
  task automatic cfg(input logic [20:0] en, input logic [20:0] pr,
      input logic ga);
    apb(1'b1, OFS_FIRST_EN, {24'h0, ga, en[6:0]});
    apb(1'b1, OFS_SECOND_EN, {24'h0, en[14:7]});
    apb(1'b1, OFS_THIRD_EN, {26'h0, en[20:15]});
    apb(1'b1, OFS_FIRST_PRIO, {25'h0, pr[6:0]});
    apb(1'b1, OFS_SECOND_PRIO, {24'h0, pr[14:7]});
    apb(1'b1, OFS_THIRD_PRIO, {26'h0, pr[20:15]});
  endtask
  // Optionally clear flags, then a return at the next boundary
  task automatic leave(input bit clr);
    int n;
    n = 0;
    if (clr) begin
      apb(1'b1, OFS_PEND_A, 32'h0);
      apb(1'b1, OFS_PEND_B, 32'h0);
    end
    return_from_interrupt_next <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_seq.insn_last !== 1'b1 && n < 30);
    return_from_interrupt_next <= 1'b0;
  endtask
  task automatic chk_vec(input int o, input logic hi);
    cmp1(got, 1'b1, "call");
    cmp32({16'h0, cpu_req.vector}, {16'h0, FIRST_VECTOR} + 32'(o) * 8,
      "vector");
    cmp1(cpu_req.high, hi, "level");
  endtask
  // One source from flag to return
  task automatic service(input int o, input bit b, input bit hi,
      input logic [20:0] extra);
    logic [20:0] m;
    m = 21'h1 << o;
    pulse(b ? extra : (m | extra), b ? m : 21'h0);
    wait_req(30);
    chk_vec(o, hi);
    apb(1'b0, b ? OFS_PEND_B : OFS_PEND_A, 32'h0);
    cmp1(q[o], !(o == 0 || o == 2) || b, "flag kept");
    leave(1'b1);
  endtask

  initial begin
    #300000;
    miscompares++;
    $display("FAIL %0t watchdog", $time);
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    flag_set_a = 21'h0;
    flag_set_b = 21'h0;
    insn_len = 4'h1;
    stall_in = 1'b0;
    return_from_interrupt_next = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      cfg(21'h1 << rows[i].ord, rows[i].hi ? 21'h1 << rows[i].ord : 21'h0,
        1'b1);
      service(rows[i].ord, rows[i].use_b, rows[i].hi, 21'h0);
      $display("Row %0d done", i);
    end
    // Reset contents, unmapped place, reserved order
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp32({16'h0, cpu_req.vector}, 32'h0, "vector reset");
    apb(1'b0, OFS_FIRST_PRIO, 32'h0);
    cmp32(q, 32'h80, "prio reset");
    apb(1'b0, 8'h24, 32'h0);
    cmp32({31'h0, err} ^ q, 32'h1, "unmapped");
    cfg(21'h1FFFFF, 21'h0, 1'b1);
    apb(1'b0, OFS_THIRD_EN, 32'h0);
    cmp32(q, 32'h3B, "reserved enable");
    pulse(RESERVED_MASK, 21'h0);
    wait_req(15);
    cmp1(got, 1'b0, "reserved call");
    $display("Reset test done");
    // Global gate and disabled source keep the flag only
    cfg(21'h40, 21'h0, 1'b0);
    pulse(21'h40, 21'h0);
    wait_req(15);
    cmp1(got, 1'b0, "global off");
    apb(1'b0, OFS_PEND_A, 32'h0);
    cmp1(q[6], 1'b1, "flag set");
    apb(1'b1, OFS_FIRST_EN, 32'h80);
    wait_req(15);
    cmp1(got, 1'b0, "source off");
    apb(1'b1, OFS_FIRST_EN, 32'hC0);
    wait_req(30);
    chk_vec(6, 1'b0);
    leave(1'b1);
    $display("Gate test done");
    // Same-clock pair: lower order, then higher level; fastest answer
    cfg(21'h28, 21'h0, 1'b1);
    service(3, 0, 0, 21'h20);
    cmp32(32'(cyc), 32'h4, "latency");
    cfg(21'h28, 21'h20, 1'b1);
    service(5, 0, 1, 21'h8);
    $display("Order test done");
    // Nesting with three-clock instructions
    insn_len <= 4'h3;
    cfg(21'h213, 21'h3, 1'b1);
    pulse(21'h10, 21'h0);
    wait_req(30);
    chk_vec(4, 1'b0);
    pulse(21'h200, 21'h0);
    wait_req(25);
    cmp1(got, 1'b0, "equal level");
    pulse(21'h2, 21'h0);
    wait_req(30);
    chk_vec(1, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp32(q & 32'hFFFF_0003, {FIRST_VECTOR + 16'h0008, 16'h0003},
      "nest status");
    pulse(21'h1, 21'h0);
    wait_req(25);
    cmp1(got, 1'b0, "high blocks");
    leave(1'b0);
    wait_req(30);
    chk_vec(0, 1'b1);
    cmp32(32'(cyc), 32'h5, "after return");
    leave(1'b1);
    leave(1'b1);
    insn_len <= 4'h1;
    $display("Nesting test done");
    // Software-set flag, then a stalled core
    cfg(21'h20, 21'h0, 1'b1);
    apb(1'b1, OFS_PEND_A, 32'h20);
    wait_req(30);
    chk_vec(5, 1'b0);
    leave(1'b1);
    stall_in <= 1'b1;
    pulse(21'h20, 21'h0);
    wait_req(20);
    cmp1(got, 1'b0, "stalled");
    stall_in <= 1'b0;
    wait_req(30);
    chk_vec(5, 1'b0);
    cmp32(32'(cyc), 32'h3, "after stall");
    leave(1'b1);
    $display("Stall test done");
    // Flag left set across a return, then an eight-clock instruction
    insn_len <= 4'h8;
    pulse(21'h20, 21'h0);
    wait_req(40);
    chk_vec(5, 1'b0);
    leave(1'b0);
    wait_req(40);
    chk_vec(5, 1'b0);
    cmp32(32'(cyc), 32'hA, "long after return");
    leave(1'b1);
    insn_len <= 4'h1;
    $display("Long instruction test done");
    results();
  end
endmodule
`default_nettype wire
